/* File: hdl/l2_cfg.sv */
// Second-level cache control register and the RAM-side logic it configures
// How it works
// R1 - Parity enabled: generate byte parity on writes, check it on reads.
// R2 - Parity disabled: written parity is all zero, no parity errors flagged.
// R3 - Capacity code 01/10/11 gives 256K/512K/1M; address width follows; 00 reserved.
// R4 - Attached data RAM is 64 bits wide, 32K/64K/128K words deep.
// R5 - Ratio code divides core clock by 1, 1.5, 2, 2.5 or 3.
// R6 - Ratio zero stops the RAM clock and turns the DLL off.
// R7 - Any nonzero ratio runs the RAM clock and enables the DLL; reserved codes 3 and 7 keep the clock stopped and the DLL off here.
// R8 - Software waits for the DLL to settle before enabling the cache.
// R9 - Software keeps the RAM clock no slower than the system bus clock.
// R10 - RAM type picks flow-through, pipelined or late-write (pipelined timing).
// R11 - Late-write: write data follows the write enable by one RAM cycle.
// R12 - Burst RAMs never burst; every access carries a fresh address.
// R13 - Flow-through RAMs only with divide-by-2 or slower.
// R14 - Data-only mode treats instruction-cache transactions as uncached.
// R15 - Setting global invalidate clears every tag status entry.
// R16 - Software never sets global invalidate while the cache is enabled.
// R17 - Enable takes effect from the next transaction received.
// R18 - Bit 31 reads one while invalidate runs, zero when done.
// R19 - Software never writes reserved field codes; response undefined.
`timescale 1ns/1ns
module l2_cfg (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // Special register move port
    input  wire logic                         spr_we,
    input  wire logic [31:0]                  spr_wdata,
    output logic      [31:0]                  spr_rdata,
    // Transactions from the first-level caches
    input  wire logic                         txn_valid,
    input  wire logic                         txn_from_icache,
    output logic                              txn_cacheable,
    // Data access requests
    input  wire logic                         acc_valid,
    input  wire logic                         acc_write,
    input  wire logic [l2_cfg_pkg::ADDR_W-1:0] acc_addr,
    input  wire logic [l2_cfg_pkg::DATA_W-1:0] acc_wdata,
    output logic                              acc_ready,
    output logic                              rd_valid,
    output logic      [l2_cfg_pkg::DATA_W-1:0] rd_data,
    output logic                              parity_error,
    // Data RAM side
    output l2_cfg_pkg::ram_bus_t              ram,
    input  wire logic [l2_cfg_pkg::DATA_W-1:0] ram_rdata,
    input  wire logic [l2_cfg_pkg::PAR_W-1:0]  ram_rpar,
    output logic                              ram_clk_tick,
    output logic                              dll_enable,
    // Tag array clear port
    output logic                              tag_clear,
    output logic      [l2_cfg_pkg::TAG_IDX_W-1:0] tag_clear_idx
);
    typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WDATA, S_RWAIT} acc_state_t;

    logic [31:0]                   ctrl;
    logic                          in_prog;
    logic [2:0]                    phase;
    logic [2:0]                    half_div;
    logic [3:0]                    next_phase;
    acc_state_t                    state;
    logic                          req_write;
    logic [l2_cfg_pkg::ADDR_W-1:0] req_addr;
    logic [l2_cfg_pkg::DATA_W-1:0] req_wdata;
    logic [1:0]                    wait_cnt;
    logic [l2_cfg_pkg::ADDR_W-1:0] addr_mask;
    logic [l2_cfg_pkg::PAR_W-1:0]  chk_par;

    wire logic       par_on    = ctrl[l2_cfg_pkg::BIT_PARITY];
    wire logic       cache_on  = ctrl[l2_cfg_pkg::BIT_ENABLE];
    wire logic [1:0] cap_sel   = ctrl[l2_cfg_pkg::POS_CAPACITY +: 2];
    wire logic [2:0] ratio     = ctrl[l2_cfg_pkg::POS_RATIO +: 3];
    wire logic [1:0] ram_type  = ctrl[l2_cfg_pkg::POS_RAMTYPE +: 2];
    wire logic       late_wr   = (ram_type == l2_cfg_pkg::RAM_LATEW);
    wire logic       inval_req = spr_we && spr_wdata[l2_cfg_pkg::BIT_INVAL] && !in_prog;

    // Byte parity of a data word, even sense
    function automatic logic [l2_cfg_pkg::PAR_W-1:0] byte_par(
        input logic [l2_cfg_pkg::DATA_W-1:0] d);
        logic [l2_cfg_pkg::PAR_W-1:0] p;
        p = '0;
        for (int i = 0; i < l2_cfg_pkg::PAR_W; i++) begin
            p[i] = ^d[i*8 +: 8];
        end
        return p;
    endfunction

    // Control register; bit 31 is owned by the invalidate walker
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= l2_cfg_pkg::CTRL_RESET;
        end else if (spr_we) begin
            ctrl <= spr_wdata & l2_cfg_pkg::CTRL_WR_MASK;
        end
    end

    // Read-back copy with live in-progress flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spr_rdata <= l2_cfg_pkg::CTRL_RESET;
        end else begin
            spr_rdata <= {in_prog, ctrl[30:0]};
        end
    end

    // R15 tag walk: a write carrying the invalidate bit clears every tag entry
    // R18 flag: in_prog stays high from that write until the last entry clears
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_prog       <= 1'b0;
            tag_clear     <= 1'b0;
            tag_clear_idx <= '0;
        end else if (inval_req) begin
            in_prog       <= 1'b1;
            tag_clear     <= 1'b1;
            tag_clear_idx <= '0;
        end else if (tag_clear) begin
            if (tag_clear_idx == l2_cfg_pkg::TAG_LAST) begin
                in_prog   <= 1'b0;
                tag_clear <= 1'b0;
            end else begin
                tag_clear_idx <= tag_clear_idx + 12'h001;
            end
        end
    end

    // Divisor in half core cycles for each ratio code
    always_comb begin
        case (ratio)
            l2_cfg_pkg::RATIO_1:   half_div = 3'h2;
            l2_cfg_pkg::RATIO_1P5: half_div = 3'h3;
            l2_cfg_pkg::RATIO_2:   half_div = 3'h4;
            l2_cfg_pkg::RATIO_2P5: half_div = 3'h5;
            l2_cfg_pkg::RATIO_3:   half_div = 3'h6;
            default:               half_div = 3'h0; // Off and reserved codes
        endcase
    end

    assign next_phase = {1'b0, phase} + {1'b0, l2_cfg_pkg::HALF_STEP};

    // R5 divider: accumulator yields one RAM tick per ratio core cycles on average
    // R6 stop: ratio zero holds the tick low and the DLL off
    // R7 run: the five valid nonzero ratio codes tick and enable the DLL; reserved codes 3 and 7 stay stopped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase        <= '0;
            ram_clk_tick <= 1'b0;
            dll_enable   <= 1'b0;
        end else if (half_div == 3'h0) begin
            phase        <= '0;
            ram_clk_tick <= 1'b0;
            dll_enable   <= 1'b0;
        end else begin
            dll_enable <= 1'b1;
            if (next_phase >= {1'b0, half_div}) begin
                phase        <= 3'(next_phase - {1'b0, half_div});
                ram_clk_tick <= 1'b1;
            end else begin
                phase        <= next_phase[2:0];
                ram_clk_tick <= 1'b0;
            end
        end
    end

    // R3 capacity: address bits above the selected size are forced low
    always_comb begin
        case (cap_sel)
            l2_cfg_pkg::CAP_256K: addr_mask = 17'h07FFF;
            l2_cfg_pkg::CAP_512K: addr_mask = 17'h0FFFF;
            l2_cfg_pkg::CAP_1M:   addr_mask = 17'h1FFFF;
            default:              addr_mask = 17'h00000;
        endcase
    end

    // R14 data-only: instruction fetch traffic bypasses the cache
    // R17 enable: the registered flag governs the next transaction seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txn_cacheable <= 1'b0;
        end else begin
            txn_cacheable <= txn_valid && cache_on && !in_prog
                && !(ctrl[l2_cfg_pkg::BIT_DATA_ONLY] && txn_from_icache);
        end
    end

    // Parity expected on read data
    assign chk_par = byte_par(ram_rdata);

    // Access sequencer, advancing on RAM clock ticks
    // R12 no burst: each access drives its own address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= S_IDLE;
            acc_ready    <= 1'b0;
            req_write    <= 1'b0;
            req_addr     <= '0;
            req_wdata    <= '0;
            wait_cnt     <= '0;
            ram          <= '0;
            rd_valid     <= 1'b0;
            rd_data      <= '0;
            parity_error <= 1'b0;
        end else begin
            rd_valid     <= 1'b0;
            parity_error <= 1'b0;
            // R2 parity off: stale parity from an earlier write is dropped at once
            if (!par_on) begin
                ram.wpar <= '0;
            end
            case (state)
                S_IDLE: begin
                    acc_ready <= cache_on && !in_prog && dll_enable;
                    if (acc_valid && acc_ready) begin
                        acc_ready <= 1'b0;
                        req_write <= acc_write;
                        req_addr  <= acc_addr & addr_mask;
                        req_wdata <= acc_wdata;
                        state     <= S_ISSUE;
                    end
                end
                S_ISSUE: if (ram_clk_tick) begin
                    ram.addr <= req_addr;
                    ram.we   <= req_write;
                    // R11 late write: data waits for the following RAM cycle
                    if (req_write && late_wr) begin
                        state <= S_WDATA;
                    end else if (req_write) begin
                        ram.wdata <= req_wdata;
                        // R1 R2 parity generate: zero when disabled
                        ram.wpar  <= par_on ? byte_par(req_wdata) : '0;
                        state     <= S_WDATA;
                    end else begin
                        // R10 timing: flow-through reads one tick earlier
                        wait_cnt <= (ram_type == l2_cfg_pkg::RAM_FLOW)
                            ? l2_cfg_pkg::LAT_FLOW : l2_cfg_pkg::LAT_PIPE;
                        state    <= S_RWAIT;
                    end
                end
                S_WDATA: if (ram_clk_tick) begin
                    ram.we <= 1'b0;
                    if (late_wr) begin
                        ram.wdata <= req_wdata;
                        ram.wpar  <= par_on ? byte_par(req_wdata) : '0;
                    end
                    state <= S_IDLE;
                end
                S_RWAIT: if (ram_clk_tick) begin
                    if (wait_cnt == 2'h1) begin
                        rd_valid     <= 1'b1;
                        rd_data      <= ram_rdata;
                        // R1 R2 parity check: only flagged while enabled
                        parity_error <= par_on && (chk_par != ram_rpar);
                        state        <= S_IDLE;
                    end
                    wait_cnt <= wait_cnt - 2'h1;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_par_off_zero;
        !par_on |=> (ram.wpar == '0);
    endproperty
    a_par_off_zero: assert property (p_par_off_zero) else $error("parity not zero"); // R2

    property p_no_perr_off;
        (!par_on && !spr_we) |=> !parity_error;
    endproperty
    a_no_perr_off: assert property (p_no_perr_off) else $error("parity error while off"); // R2

    property p_par_gen;
        (par_on && !late_wr && state == S_ISSUE && ram_clk_tick && req_write && !spr_we)
            |=> (ram.wpar == byte_par(ram.wdata));
    endproperty
    a_par_gen: assert property (p_par_gen) else $error("bad write parity"); // R1

    property p_clk_stop;
        (ratio == l2_cfg_pkg::RATIO_OFF && !spr_we) |=> (!ram_clk_tick && !dll_enable);
    endproperty
    a_clk_stop: assert property (p_clk_stop) else $error("RAM clock not stopped"); // R6

    property p_div1;
        (ratio == l2_cfg_pkg::RATIO_1) [*3] |-> ram_clk_tick;
    endproperty
    a_div1: assert property (p_div1) else $error("divide by one missed tick"); // R5

    property p_div3;
        (ratio == l2_cfg_pkg::RATIO_3) [*4] ##0 ram_clk_tick |-> !$past(ram_clk_tick);
    endproperty
    a_div3: assert property (p_div3) else $error("divide by three ticks too fast"); // R5

    property p_dll_on;
        (half_div != 3'h0) |=> dll_enable;
    endproperty
    a_dll_on: assert property (p_dll_on) else $error("DLL not enabled"); // R7

    property p_late_wr;
        (state == S_WDATA && late_wr && ram_clk_tick && !spr_we)
            |=> (!ram.we && ram.wdata == $past(req_wdata));
    endproperty
    a_late_wr: assert property (p_late_wr) else $error("late write data misplaced"); // R11

    property p_inval_flag;
        inval_req |=> in_prog ##1 (spr_rdata[l2_cfg_pkg::BIT_IN_PROG] && tag_clear_idx == 12'h1);
    endproperty
    a_inval_flag: assert property (p_inval_flag) else $error("invalidate flag wrong"); // R18

    property p_inval_end;
        (tag_clear && tag_clear_idx == l2_cfg_pkg::TAG_LAST && !inval_req) |=> !in_prog;
    endproperty
    a_inval_end: assert property (p_inval_end) else $error("invalidate did not finish"); // R15

    property p_data_only;
        (txn_valid && txn_from_icache && ctrl[l2_cfg_pkg::BIT_DATA_ONLY]) |=> !txn_cacheable;
    endproperty
    a_data_only: assert property (p_data_only) else $error("icache traffic cached"); // R14

    property p_enable_next;
        (txn_valid && !cache_on) |=> !txn_cacheable;
    endproperty
    a_enable_next: assert property (p_enable_next) else $error("cached while disabled"); // R17
endmodule

/* File: hdl/l2_cfg_pkg.sv */
// Shared constants and carriers for the second-level cache configuration block
package l2_cfg_pkg;
    // Control register field positions
    localparam int BIT_ENABLE    = 0;
    localparam int BIT_PARITY    = 1;
    localparam int POS_CAPACITY  = 2;
    localparam int POS_RATIO     = 4;
    localparam int POS_RAMTYPE   = 7;
    localparam int BIT_DATA_ONLY = 9;
    localparam int BIT_INVAL     = 10;
    localparam int BIT_IN_PROG   = 31;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam logic [31:0] CTRL_WR_MASK  = 32'h7FFF_FFFF; // Bit 31 is read only
    // Capacity codes
    localparam logic [1:0] CAP_256K = 2'h1;
    localparam logic [1:0] CAP_512K = 2'h2;
    localparam logic [1:0] CAP_1M   = 2'h3;
    // Clock ratio codes and divisor in half steps
    localparam logic [2:0] RATIO_OFF = 3'h0;
    localparam logic [2:0] RATIO_1   = 3'h1;
    localparam logic [2:0] RATIO_1P5 = 3'h2;
    localparam logic [2:0] RATIO_2   = 3'h4;
    localparam logic [2:0] RATIO_2P5 = 3'h5;
    localparam logic [2:0] RATIO_3   = 3'h6;
    localparam logic [2:0] HALF_STEP = 3'h2;
    // RAM type codes
    localparam logic [1:0] RAM_FLOW  = 2'h0;
    localparam logic [1:0] RAM_PIPE  = 2'h2;
    localparam logic [1:0] RAM_LATEW = 2'h3;
    // Read latency in RAM clock ticks
    localparam logic [1:0] LAT_FLOW  = 2'h1;
    localparam logic [1:0] LAT_PIPE  = 2'h2;
    // Tag array walked by a global invalidate
    localparam int TAG_IDX_W = 12;
    localparam logic [TAG_IDX_W-1:0] TAG_LAST = 12'hFFF;
    // Data RAM geometry
    localparam int ADDR_W = 17;
    localparam int DATA_W = 64;
    localparam int PAR_W  = 8;

    // Signals driven toward the data RAM
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              we;
        logic [DATA_W-1:0] wdata;
        logic [PAR_W-1:0]  wpar;
    } ram_bus_t;
endpackage

/* File: tb/sram_model.sv */
// Behavioural synchronous SRAM on the cache data port
`timescale 1ns/1ns
module sram_model (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Cache side bus and test controls
    input  wire l2_cfg_pkg::ram_bus_t ram,
    input  wire logic                 ram_clk_tick,
    input  wire logic [1:0]           ram_type,
    input  wire logic                 corrupt,
    // Read return and last parity stored
    output logic      [63:0]          ram_rdata,
    output logic      [7:0]           ram_rpar,
    output logic      [7:0]           last_par
);
    logic [71:0] mem [logic [16:0]];
    logic [71:0] pipe_q;
    logic [71:0] word;
    logic        lw_pend;
    logic [16:0] lw_addr;
    int          wr_cnt;

    // Unwritten words read back as a changing pattern, never a stale match
    function automatic logic [71:0] look(input logic [16:0] a);
        return mem.exists(a) ? mem[a] : {8'h5A, ~ram.wdata};
    endfunction

    // Writes and the pipelined read stage move on RAM clock ticks
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lw_pend  <= 1'b0;
            lw_addr  <= 17'h00000;
            pipe_q   <= 72'h0;
            last_par <= 8'h00;
        end else if (ram_clk_tick) begin
            pipe_q  <= look(ram.addr);
            lw_pend <= 1'b0;
            if (lw_pend) begin
                mem[lw_addr] = {ram.wpar, ram.wdata};
                last_par     <= ram.wpar;
                wr_cnt       = wr_cnt + 1;
            end
            if (ram.we && ram_type == l2_cfg_pkg::RAM_LATEW) begin
                lw_pend <= 1'b1;
                lw_addr <= ram.addr;
            end else if (ram.we) begin
                mem[ram.addr] = {ram.wpar, ram.wdata};
                last_par      <= ram.wpar;
                wr_cnt        = wr_cnt + 1;
            end
        end
    end

    always @(ram.addr or wr_cnt or pipe_q or ram_type or corrupt) begin
        word      = (ram_type == l2_cfg_pkg::RAM_FLOW) ? look(ram.addr) : pipe_q;
        ram_rdata = word[63:0];
        ram_rpar  = word[71:64] ^ {7'h00, corrupt};
    end
endmodule

/* File: tb/tb_l2_cfg.sv */
// Self-checking bench for the cache control register and RAM-side logic
`timescale 1ns/1ns
module tb_l2_cfg;
    logic        clk = 1'b0, rst_n = 1'b1, spr_we = 1'b0, txn_valid = 1'b0;
    logic        txn_from_icache = 1'b0, acc_valid = 1'b0, acc_write = 1'b0;
    logic        corrupt = 1'b0, txn_d = 1'b0;
    logic        txn_cacheable, acc_ready, rd_valid, parity_error, ram_clk_tick;
    logic        dll_enable, tag_clear;
    logic [31:0] spr_wdata = 32'h0, seed = 32'hC, spr_rdata, a;
    logic [16:0] acc_addr = 17'h0;
    logic [63:0] acc_wdata = 64'h0, rd_data, ram_rdata, d;
    logic [64:0] exp_rd;
    logic [7:0]  ram_rpar, last_par;
    logic [1:0]  ram_type = 2'h0;
    logic [11:0] tag_clear_idx, last_idx;
    l2_cfg_pkg::ram_bus_t ram;
    logic [64:0] q_rd[$];
    logic        q_txn[$];
    int          err_total = 0, checks = 0, n;
    int          tk[8] = '{0, 120, 80, 0, 60, 48, 40, 0};
    logic [1:0]  ty[3] = '{2'h0, 2'h2, 2'h3};
    logic [16:0] cm[4] = '{17'h0, 17'h07FFF, 17'h0FFFF, 17'h1FFFF};

    // Clock at 100 MHz
    always #5 clk = ~clk;

    l2_cfg dut (.clk(clk), .rst_n(rst_n), .spr_we(spr_we), .spr_wdata(spr_wdata),
        .spr_rdata(spr_rdata), .txn_valid(txn_valid), .txn_from_icache(txn_from_icache),
        .txn_cacheable(txn_cacheable), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ready(acc_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .parity_error(parity_error), .ram(ram),
        .ram_rdata(ram_rdata), .ram_rpar(ram_rpar), .ram_clk_tick(ram_clk_tick),
        .dll_enable(dll_enable), .tag_clear(tag_clear), .tag_clear_idx(tag_clear_idx));

    sram_model mem_dev (.clk(clk), .rst_n(rst_n), .ram(ram), .ram_clk_tick(ram_clk_tick),
        .ram_type(ram_type), .corrupt(corrupt), .ram_rdata(ram_rdata),
        .ram_rpar(ram_rpar), .last_par(last_par));

    // Compare and count
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // A wait that ran out counts as a mismatch
    task automatic tmo();
        err_total++;
        final_report();
    endtask

    // Xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Even parity, one bit per byte
    function automatic logic [7:0] par(input logic [63:0] v);
        for (int i = 0; i < 8; i++) begin
            par[i] = ^v[8*i +: 8];
        end
    endfunction

    // Control word from its fields
    function automatic logic [31:0] cfg(input logic en, pe, input logic [1:0] cap,
        input logic [2:0] rt, input logic [1:0] rty, input logic dno, inv);
        return {21'h0, inv, dno, rty, rt, cap, pe, en};
    endfunction

    // Register write, returning once the readback has settled
    task automatic wr(input logic [31:0] v);
        spr_we    <= 1'b1;
        spr_wdata <= v;
        @(posedge clk);
        spr_we    <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // One access, held until taken, then wait for the sequencer to go idle
    task automatic acc(input logic w, input logic [16:0] ad, input logic [63:0] dv,
        input logic pe);
        if (!w) begin
            q_rd.push_back({pe, dv});
        end
        acc_valid <= 1'b1;
        acc_write <= w;
        acc_addr  <= ad;
        acc_wdata <= dv;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (acc_ready !== 1'b1 && n < 300);
        acc_valid <= 1'b0;
        repeat (2) @(posedge clk);
        while (acc_ready !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        if (acc_ready !== 1'b1) begin
            tmo();
        end
    endtask

    // Pair each result seen at the outputs with the oldest expectation
    always @(posedge clk) begin
        if (txn_d) begin
            chk("txn_cacheable", q_txn.pop_front(), txn_cacheable);
        end
        txn_d = (txn_valid === 1'b1);
        if (rd_valid === 1'b1) begin
            exp_rd = q_rd.pop_front();
            chk("rd_data", exp_rd[63:0], rd_data);
            chk("parity_error", exp_rd[64], parity_error);
        end
    end

    // Main sequence
    initial begin
        // Falling edge at time zero so the asynchronous reset really fires
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("spr_rdata_reset", 64'h0, spr_rdata);
        for (int i = 0; i < 8; i++) begin
            wr(cfg(1'b0, 1'b0, 2'h3, i[2:0], 2'h2, 1'b0, 1'b0) | 32'h8000_0000);
            chk("ctrl_readback", cfg(1'b0, 1'b0, 2'h3, i[2:0], 2'h2, 1'b0, 1'b0), spr_rdata);
            repeat (10) @(posedge clk);
            n = 0;
            repeat (120) begin
                @(posedge clk);
                n += int'(ram_clk_tick === 1'b1);
            end
            chk("ram_clk_ticks", tk[i], n);
            chk("dll_enable", i != 0 && i != 3 && i != 7, dll_enable);
        end
        $display("test ratio done");
        wr(cfg(1'b0, 1'b0, 2'h3, 3'h4, 2'h2, 1'b0, 1'b1));
        chk("in_progress", 1'b1, spr_rdata[31]);
        n = 0;
        while (tag_clear === 1'b1 && n < 5000) begin
            last_idx = tag_clear_idx;
            n++;
            @(posedge clk);
        end
        @(posedge clk);
        chk("walk_length", 4095, n);
        chk("walk_last_idx", 12'hFFF, last_idx);
        chk("ctrl_after_walk", 32'h0000_054C, spr_rdata);
        $display("test invalidate done");
        for (int m = 0; m < 3; m++) begin
            wr(cfg(m != 2, 1'b0, 2'h3, 3'h4, 2'h2, m != 0, 1'b0));
            txn_valid <= 1'b1;
            for (int k = 0; k < 2; k++) begin
                txn_from_icache <= k[0];
                q_txn.push_back(m != 2 && !(m == 1 && k == 1));
                @(posedge clk);
            end
            txn_valid <= 1'b0;
            @(posedge clk);
        end
        $display("test transactions done");
        for (int i = 0; i < 6; i++) begin
            ram_type <= ty[i/2];
            wr(cfg(1'b1, i[0], 2'h3, 3'h4, ty[i/2], 1'b0, 1'b0));
            a = rnd();
            d = {rnd(), rnd()};
            acc(1'b1, a[16:0], d, 1'b0);
            acc(1'b0, a[16:0], d, 1'b0);
            chk("stored_parity", i[0] ? par(d) : 8'h00, last_par);
            chk("read_addr", a[16:0], ram.addr);
            corrupt <= 1'b1;
            acc(1'b0, a[16:0], d, i[0]);
            corrupt <= 1'b0;
        end
        $display("test access done");
        for (int i = 1; i < 4; i++) begin
            wr(cfg(1'b1, 1'b0, i[1:0], 3'h4, 2'h2, 1'b0, 1'b0));
            acc(1'b1, 17'h1FFFF, d, 1'b0);
            chk("ram_addr_cap", cm[i], ram.addr);
        end
        $display("test capacity done");
        chk("reads_left", 0, q_rd.size());
        final_report();
    end
endmodule
